/* rtl/llmi_monitor.sv */
// lock-loss monitor, status flags and interrupt pin behind Avalon-MM
`timescale 1ns/1ps
// Operation
// - set lock-loss bit when loop loses lock
// - lock-loss pin follows live monitor state
// - decide from phase detector frequency difference
// - separate set and clear comparators, hysteresis
// - optional timer delays clearing lock-loss
// - live bit plus sticky bit cleared by software
// - thresholds programmable, 0.1 to 10,000 ppm
// - example: lock below 0.1, loss above 1 ppm
// - interrupt on any indicator change
// - each indicator maskable from interrupt
// - interrupt releases only after sticky clear or mask write
// - signal and frequency indicators: live and sticky
module llmi_monitor (
    // clock and reset
    input  wire logic                           clk_i,
    input  wire logic                           rst_i,
    // Avalon-MM slave
    input  wire logic [llmi_pkg::ADDR_W-1:0]    avs_address_i,
    input  wire logic                           avs_read_i,
    input  wire logic                           avs_write_i,
    input  wire logic [llmi_pkg::DATA_W-1:0]    avs_writedata_i,
    input  wire logic [llmi_pkg::BE_W-1:0]      avs_byteenable_i,
    output logic      [llmi_pkg::DATA_W-1:0]    avs_readdata_o,
    output logic                                avs_waitrequest_o,
    // monitor inputs
    input  wire logic [llmi_pkg::THR_W-1:0]     pd_freq_diff_i,
    input  wire logic                           signal_missing_i,
    input  wire logic                           freq_out_of_range_i,
    input  wire logic                           holdover_i,
    // status pins
    output logic                                lock_lost_o,
    output logic                                irq_n_o
);
    import llmi_pkg::*;

    llmi_state_t       st_reg;
    llmi_state_t       st_next;
    logic              acc;
    logic              wr_acc;
    logic              rd_acc;
    logic              sticky_wr;
    logic              mask_wr;
    logic              above_set;
    logic              below_clr;
    logic              lost_next;
    logic [IND_W-1:0]  changed;
    // merged write word, zero while no write completes
    logic [DATA_W-1:0] wr_word;

    // byte-lane merge, bits beyond the register width fall away
    function automatic logic [DATA_W-1:0] merge(
        input logic [DATA_W-1:0] old_v,
        input logic [DATA_W-1:0] new_v,
        input logic [BE_W-1:0]   be
    );
        logic [DATA_W-1:0] r;
        r = old_v;
        for (int i = 0; i < BE_W; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // =====================================================================
    // bus handshake: one wait state, the access completes when wait is low
    assign acc       = (avs_read_i | avs_write_i) & ~st_reg.wait_req;
    assign wr_acc    = acc & avs_write_i;
    assign rd_acc    = acc & avs_read_i;
    assign sticky_wr = wr_acc && (avs_address_i == OFS_STICKY);
    assign mask_wr   = wr_acc && (avs_address_i == OFS_MASK);

    // =====================================================================
    // comparators: one asserts loss, the other allows clearing
    assign above_set = pd_freq_diff_i > st_reg.set_thr;
    assign below_clr = pd_freq_diff_i < st_reg.clr_thr;

    // next state of the whole block
    always_comb begin
        st_next  = st_reg;
        lost_next = st_reg.live[BIT_LOCK_LST];
        // lock-loss decision; the band between thresholds holds the state
        if (above_set) begin
            lost_next        = 1'b1;
            st_next.dly_cnt  = '0;
        end else if (st_reg.live[BIT_LOCK_LST] && below_clr) begin
            // a delay lets acquisition finish without chattering
            if (st_reg.dly_cnt >= st_reg.clr_dly) begin
                lost_next       = 1'b0;
                st_next.dly_cnt = '0;
            end else begin
                st_next.dly_cnt = st_reg.dly_cnt + 1'b1;
            end
        end else begin
            st_next.dly_cnt = '0;
        end
        st_next.live[BIT_LOCK_LST] = lost_next;
        st_next.live[BIT_SIG_MISS] = signal_missing_i;
        st_next.live[BIT_FREQ_OOR] = freq_out_of_range_i;
        st_next.live[BIT_HOLDOVER] = holdover_i;
        changed = st_next.live ^ st_reg.live;

        // register writes take effect on the completing edge
        wr_word = '0;
        if (wr_acc) begin
            case (avs_address_i)
                OFS_MASK: begin
                    wr_word = merge({28'h0, st_reg.mask},
                        avs_writedata_i, avs_byteenable_i);
                    st_next.mask = wr_word[IND_W-1:0];
                end
                OFS_SET_THR: begin
                    wr_word = merge({15'h0, st_reg.set_thr},
                        avs_writedata_i, avs_byteenable_i);
                    st_next.set_thr = wr_word[THR_W-1:0];
                end
                OFS_CLR_THR: begin
                    wr_word = merge({15'h0, st_reg.clr_thr},
                        avs_writedata_i, avs_byteenable_i);
                    st_next.clr_thr = wr_word[THR_W-1:0];
                end
                OFS_CLR_DLY: begin
                    wr_word = merge({8'h0, st_reg.clr_dly},
                        avs_writedata_i, avs_byteenable_i);
                    st_next.clr_dly = wr_word[DLY_W-1:0];
                end
                default: begin
                end
            endcase
        end

        // sticky: write one to clear, a change in the same cycle wins
        st_next.sticky = st_reg.sticky;
        if (sticky_wr && avs_byteenable_i[0]) begin
            st_next.sticky = st_reg.sticky & ~avs_writedata_i[IND_W-1:0];
        end
        st_next.sticky = st_next.sticky | changed;

        // pin is low while any unmasked sticky flag stands
        st_next.irq_n = ~|(st_next.sticky & ~st_next.mask);

        // handshake and read data
        st_next.wait_req = ~((avs_read_i | avs_write_i) & st_reg.wait_req);
        st_next.rdata    = st_reg.rdata;
        if ((avs_read_i | avs_write_i) && st_reg.wait_req) begin
            case (avs_address_i)
                OFS_LIVE:    st_next.rdata = {28'h0, st_reg.live};
                OFS_STICKY:  st_next.rdata = {28'h0, st_reg.sticky};
                OFS_MASK:    st_next.rdata = {28'h0, st_reg.mask};
                OFS_SET_THR: st_next.rdata = {15'h0, st_reg.set_thr};
                OFS_CLR_THR: st_next.rdata = {15'h0, st_reg.clr_thr};
                OFS_CLR_DLY: st_next.rdata = {8'h0, st_reg.clr_dly};
                default:     st_next.rdata = RD_UNMAPPED;
            endcase
        end
    end

    // state register
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_reg.live     <= RST_LIVE;
            st_reg.sticky   <= '0;
            st_reg.mask     <= RST_MASK;
            st_reg.set_thr  <= RST_SET_THR;
            st_reg.clr_thr  <= RST_CLR_THR;
            st_reg.clr_dly  <= RST_CLR_DLY;
            st_reg.dly_cnt  <= '0;
            st_reg.wait_req <= 1'b1;
            st_reg.rdata    <= RD_UNMAPPED;
            st_reg.irq_n    <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from the state flops
    assign avs_readdata_o    = st_reg.rdata;
    assign avs_waitrequest_o = st_reg.wait_req;
    assign lock_lost_o       = st_reg.live[BIT_LOCK_LST];
    assign irq_n_o           = st_reg.irq_n;

    // =====================================================================
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_set_asserts: assert property (
        above_set |=> lock_lost_o)
        else $error("lock-loss not set above set threshold");

    chk_band_holds: assert property (
        lock_lost_o && !above_set && !below_clr |=> lock_lost_o)
        else $error("lock-loss cleared inside hysteresis band");

    chk_delay_blocks: assert property (
        lock_lost_o && below_clr && !above_set
        && st_reg.clr_dly != 0 && st_reg.dly_cnt == 0 |=> lock_lost_o)
        else $error("lock-loss cleared before delay ran");

    // the edge that drops reset still finds the flops held, so skip it
    chk_fast_clear: assert property (
        !rst_i && lock_lost_o && below_clr && !above_set
        && st_reg.clr_dly == 0 |=> !lock_lost_o)
        else $error("lock-loss not cleared below clear threshold");

    chk_sticky_change: assert property (
        lock_lost_o != $past(lock_lost_o) |-> st_reg.sticky[BIT_LOCK_LST])
        else $error("sticky not set on lock-loss change");

    chk_live_signal: assert property (
        ##1 st_reg.live[BIT_SIG_MISS] == $past(signal_missing_i))
        else $error("signal-missing live bit lags");

    chk_sticky_holds: assert property (
        !sticky_wr |=> (st_reg.sticky & $past(st_reg.sticky))
                       == $past(st_reg.sticky))
        else $error("sticky flag dropped without clear");

    chk_irq_drives: assert property (
        |(st_reg.sticky & ~st_reg.mask) |-> !irq_n_o)
        else $error("interrupt high with unmasked sticky flag");

    chk_mask_blocks: assert property (
        (st_reg.sticky & ~st_reg.mask) == 0 |-> irq_n_o)
        else $error("interrupt low with all flags masked");

    chk_irq_release: assert property (
        $rose(irq_n_o) |-> $past(sticky_wr || mask_wr))
        else $error("interrupt released without software clear");

    chk_bus_answer: assert property (
        (avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
        else $error("bus answer not after one wait state");

    // comparator, delay and flag checks
    chk_rise_needs_set: assert property (
        $rose(lock_lost_o)
        |-> $past(above_set))
        else $error("lock-loss raised without set comparator");

    chk_clear_in_range: assert property (
        $fell(lock_lost_o)
        |-> $past(below_clr))
        else $error("lock-loss cleared outside clear range");

    chk_delay_expires: assert property (
        !rst_i && lock_lost_o && below_clr && !above_set
        && st_reg.dly_cnt >= st_reg.clr_dly |=> !lock_lost_o)
        else $error("lock-loss held after clear delay ran out");

    chk_count_restarts: assert property (
        !(lock_lost_o && below_clr && !above_set)
        |=> st_reg.dly_cnt == '0)
        else $error("clear delay counter not restarted");

    chk_sticky_wins: assert property (
        changed != '0
        |=> (st_reg.sticky & $past(changed)) == $past(changed))
        else $error("indicator change lost against sticky clear");

    chk_sticky_clears: assert property (
        sticky_wr && avs_byteenable_i[0] && changed == '0
        |=> (st_reg.sticky & $past(avs_writedata_i[IND_W-1:0])) == '0)
        else $error("sticky flag not cleared by write");

    chk_live_freq: assert property (
        ##1 st_reg.live[BIT_FREQ_OOR]
            == $past(freq_out_of_range_i))
        else $error("out-of-frequency live bit lags");

    chk_live_hold: assert property (
        ##1 st_reg.live[BIT_HOLDOVER]
            == $past(holdover_i))
        else $error("holdover live bit lags");

    // register bus checks
    chk_mask_write: assert property (
        mask_wr && avs_byteenable_i[0]
        |=> st_reg.mask == $past(avs_writedata_i[IND_W-1:0]))
        else $error("mask write did not land");

    chk_thr_write: assert property (
        wr_acc && avs_address_i == OFS_SET_THR && &avs_byteenable_i
        |=> st_reg.set_thr == $past(avs_writedata_i[THR_W-1:0]))
        else $error("set threshold write did not land");

    chk_read_mask: assert property (
        rd_acc && avs_address_i == OFS_MASK
        |-> avs_readdata_o[IND_W-1:0] == st_reg.mask)
        else $error("mask read back wrong");

    chk_read_unmapped: assert property (
        rd_acc && avs_address_i > OFS_CLR_DLY
        |-> avs_readdata_o == RD_UNMAPPED)
        else $error("unmapped read not zero");

endmodule : llmi_monitor

/* rtl/llmi_pkg.sv */
// constants and state type for the lock-loss monitor and status interrupt
package llmi_pkg;

    // =====================================================================
    // bus geometry
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned BE_W   = 4;

    // =====================================================================
    // register byte offsets
    localparam logic [7:0] OFS_LIVE    = 8'h00; // live indicators, read only
    localparam logic [7:0] OFS_STICKY  = 8'h04; // sticky flags, write 1 clear
    localparam logic [7:0] OFS_MASK    = 8'h08; // 1 = indicator masked
    localparam logic [7:0] OFS_SET_THR = 8'h0C; // lock-loss set threshold
    localparam logic [7:0] OFS_CLR_THR = 8'h10; // lock-loss clear threshold
    localparam logic [7:0] OFS_CLR_DLY = 8'h14; // clear delay, 0 = off

    // =====================================================================
    // indicator bit positions, shared by live, sticky and mask
    localparam int unsigned IND_W        = 4;
    localparam int unsigned BIT_SIG_MISS = 0;
    localparam int unsigned BIT_FREQ_OOR = 1;
    localparam int unsigned BIT_LOCK_LST = 2;
    localparam int unsigned BIT_HOLDOVER = 3;

    // =====================================================================
    // thresholds in units of 0.1 ppm: 1 = 0.1 ppm .. 100000 = 10,000 ppm
    localparam int unsigned THR_W   = 17;
    localparam int unsigned DLY_W   = 24;
    localparam logic [THR_W-1:0] RST_SET_THR = 17'h0000A; // 1 ppm
    localparam logic [THR_W-1:0] RST_CLR_THR = 17'h00001; // 0.1 ppm
    localparam logic [DLY_W-1:0] RST_CLR_DLY = 24'h000000;
    localparam logic [IND_W-1:0] RST_MASK    = 4'h0;
    localparam logic [IND_W-1:0] RST_LIVE    = 4'h4; // unlocked after reset
    localparam logic [DATA_W-1:0] RD_UNMAPPED = 32'h00000000;

    // =====================================================================
    // whole state of the block
    typedef struct packed {
        logic [IND_W-1:0]  live;
        logic [IND_W-1:0]  sticky;
        logic [IND_W-1:0]  mask;
        logic [THR_W-1:0]  set_thr;
        logic [THR_W-1:0]  clr_thr;
        logic [DLY_W-1:0]  clr_dly;
        logic [DLY_W-1:0]  dly_cnt;
        logic              wait_req;
        logic [DATA_W-1:0] rdata;
        logic              irq_n;
    } llmi_state_t;

endpackage : llmi_pkg

/* sim/tb_top.sv */
// self-checking bench for the lock-loss monitor and status interrupt
`timescale 1ns/1ps
module tb_top;
    import llmi_pkg::*;
    // =====================================================================
    // stimulus and observed signals
    logic              clk_i, rst_i, avs_read_i, avs_write_i;
    logic [ADDR_W-1:0] avs_address_i;
    logic [DATA_W-1:0] avs_writedata_i, avs_readdata_o, rd;
    logic [BE_W-1:0]   avs_byteenable_i;
    logic              avs_waitrequest_o, lock_lost_o, irq_n_o;
    logic [THR_W-1:0]  pd_freq_diff_i;
    logic [IND_W-1:0]  ind; // bit 2 unused: lock state comes from the diff
    int                n_fail, cmp_count;

    llmi_monitor DUT (
        .clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o),
        .pd_freq_diff_i(pd_freq_diff_i), .signal_missing_i(ind[0]),
        .freq_out_of_range_i(ind[1]), .holdover_i(ind[3]),
        .lock_lost_o(lock_lost_o), .irq_n_o(irq_n_o));

    // =====================================================================
    // clock, 200 MHz
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    // =====================================================================
    // shared tasks
    task automatic chk(input string nm, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask : cyc

    // one bus cycle; held until waitrequest is sampled low, no bound on the wait
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        avs_address_i   <= a;
        avs_writedata_i <= d;
        avs_write_i     <= wr;
        avs_read_i      <= ~wr;
        do begin
            @(posedge clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0);
        chk("bus wait states", 32'h2, 32'(n));
        rd = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i  <= 1'b0;
        @(posedge clk_i); // keeps back-to-back strobes apart
    endtask : bus

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : wrap_up

    // =====================================================================
    // scenarios
    task automatic t_reset();
        chk("pin in reset", 32'h1, 32'(lock_lost_o));
        chk("irq in reset", 32'h1, 32'(irq_n_o));
        @(posedge clk_i);
        rst_i <= 1'b0;
        cyc(3);
        bus(0, OFS_MASK, 0); chk("mask rst", 32'h0, rd);
        bus(0, OFS_SET_THR, 0); chk("set thr rst", 32'hA, rd);
        bus(0, OFS_CLR_THR, 0); chk("clr thr rst", 32'h1, rd);
        bus(0, OFS_CLR_DLY, 0); chk("dly rst", 32'h0, rd);
        bus(0, 8'h40, 0); chk("unmapped", RD_UNMAPPED, rd);
        // lock acquired out of reset: live drops, sticky catches it
        bus(0, OFS_LIVE, 0); chk("live locked", 32'h0, rd);
        bus(0, OFS_STICKY, 0); chk("sticky lock", 32'h4, rd);
        chk("irq pending", 32'h0, 32'(irq_n_o));
        // lane 0 off: the clear must not reach the flags
        avs_byteenable_i <= 4'hE;
        bus(1, OFS_STICKY, 32'hF);
        avs_byteenable_i <= 4'hF;
        bus(0, OFS_STICKY, 0); chk("sticky kept", 32'h4, rd);
        bus(1, OFS_STICKY, 32'hF); cyc(2);
        chk("irq released", 32'h1, 32'(irq_n_o));
        $display("test reset done");
    endtask : t_reset

    // value at a threshold is not beyond it; between them the state holds
    task automatic t_hyst();
        pd_freq_diff_i <= 17'h0000A; cyc(3);
        chk("at set thr", 32'h0, 32'(lock_lost_o));
        pd_freq_diff_i <= 17'h0000B; cyc(3);
        chk("above set", 32'h1, 32'(lock_lost_o));
        chk("irq on loss", 32'h0, 32'(irq_n_o));
        pd_freq_diff_i <= 17'h00005; cyc(3);
        chk("band holds", 32'h1, 32'(lock_lost_o));
        pd_freq_diff_i <= 17'h00000; cyc(3);
        chk("below clr", 32'h0, 32'(lock_lost_o));
        bus(1, OFS_STICKY, 32'hF);
        $display("test hysteresis done");
    endtask : t_hyst

    // top of the sensitivity span on the set comparator, 6,000 ppm on the clear one
    task automatic t_prog();
        bus(1, OFS_SET_THR, 32'h186A0);
        pd_freq_diff_i <= 17'h0C350; cyc(3);
        chk("wide set", 32'h0, 32'(lock_lost_o));
        pd_freq_diff_i <= 17'h186A1; cyc(3);
        chk("past max", 32'h1, 32'(lock_lost_o));
        bus(1, OFS_CLR_THR, 32'h0EA60);
        pd_freq_diff_i <= 17'h0C350; cyc(3);
        chk("wide clr", 32'h0, 32'(lock_lost_o));
        bus(1, OFS_SET_THR, 32'hA);
        bus(1, OFS_CLR_THR, 32'h1);
        pd_freq_diff_i <= 17'h00000;
        bus(1, OFS_STICKY, 32'hF);
        $display("test programming done");
    endtask : t_prog

    // delay of 3 needs 4 in-range cycles: lost until the fourth has ended
    task automatic t_delay();
        bus(1, OFS_CLR_DLY, 32'h3);
        pd_freq_diff_i <= 17'h0000B; cyc(3);
        pd_freq_diff_i <= 17'h00000; cyc(4);
        chk("delayed", 32'h1, 32'(lock_lost_o));
        cyc(1);
        chk("cleared", 32'h0, 32'(lock_lost_o));
        bus(1, OFS_CLR_DLY, 32'h0);
        bus(1, OFS_STICKY, 32'hF);
        $display("test delay done");
    endtask : t_delay

    task automatic t_irq();
        foreach (ind[i]) begin
            if (i != BIT_LOCK_LST) begin
                ind[i] <= 1'b1; cyc(3);
                chk("irq change", 32'h0, 32'(irq_n_o));
                bus(0, OFS_LIVE, 0); chk("live", 32'(1 << i), rd);
                bus(0, OFS_STICKY, 0); chk("sticky", 32'(1 << i), rd);
                ind[i] <= 1'b0; cyc(3);
                chk("irq held", 32'h0, 32'(irq_n_o));
                bus(1, OFS_STICKY, 32'(1 << i)); cyc(2);
                chk("irq clear", 32'h1, 32'(irq_n_o));
                bus(1, OFS_MASK, 32'(1 << i));
                ind[i] <= 1'b1; cyc(3);
                chk("masked", 32'h1, 32'(irq_n_o));
                ind[i] <= 1'b0;
                bus(1, OFS_STICKY, 32'hF);
                bus(1, OFS_MASK, 32'h0);
            end
        end
        $display("test interrupt done");
    endtask : t_irq

    // =====================================================================
    // main sequence and watchdog
    initial begin
        n_fail = 0;
        cmp_count = 0;
        rst_i = 1'b1;
        avs_read_i = 1'b0;
        avs_write_i = 1'b0;
        avs_address_i = '0;
        avs_writedata_i = '0;
        avs_byteenable_i = 4'hF;
        pd_freq_diff_i = '0;
        ind = 4'h0;
        cyc(3); // the fourth edge inside t_reset releases reset
        t_reset();
        t_hyst();
        t_prog();
        t_delay();
        t_irq();
        wrap_up();
    end

    initial begin
        #50000;
        n_fail++;
        wrap_up();
    end
endmodule : tb_top
